// File: verilog/ir_timer_pkg.sv
package ir_timer_pkg;

  // IO-control register offsets and the page that holds each of them.
  localparam logic [3:0] MAIN_TIMER_CONTROL_OFS = 4'h7;
  localparam logic [3:0] TIMER12_CONTROL_OFS = 4'h9;
  localparam logic [3:0] PULSE_CONTROL_OFS = 4'hA;
  localparam logic [3:0] FIRST_TIMER_PRESET_OFS = 4'hB;
  localparam logic [3:0] SECOND_TIMER_PRESET_OFS = 4'hC;
  localparam logic [3:0] HIGH_PULSE_PRESET_OFS = 4'hD;
  localparam logic [3:0] LOW_PULSE_PRESET_OFS = 4'hE;
  localparam logic [3:0] IRQ_MASK_OFS = 4'hF;
  localparam logic PAGE_PRESETS = 1'b0;
  localparam logic PAGE_CONTROLS = 1'b1;

  // Values after reset, and the counter end values.
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_LAST = 8'hFF;
  localparam logic [7:0] COUNT_ZERO = 8'h00;

  // Field positions in the main timer control register.
  localparam int INT0_EDGE_BIT = 7;
  localparam int GIE_BIT = 6;
  localparam int SRC_SEL_BIT = 5;
  localparam int PIN_EDGE_BIT = 4;
  localparam int PRESCALER_ON_BIT = 3;

  // Field positions in the two timer control registers.
  localparam int UPPER_SRC_BIT = 7;
  localparam int LOWER_SRC_BIT = 3;

  // Flag positions in the interrupt status and mask layout.
  localparam int MAIN_TIMER_FLAG = 0;
  localparam int INT0_FLAG = 1;
  localparam int TIMER_FLAG_BASE = 3;

  // Index of each preset timer.
  localparam int FIRST_IDX = 0;
  localparam int SECOND_IDX = 1;
  localparam int HIGH_IDX = 2;
  localparam int LOW_IDX = 3;

  // Last prescaler count for a ratio of 2 to the power (code plus 1).
  function automatic logic [7:0] ratio_last(input logic [2:0] code);
    logic [8:0] ratio;
    ratio = 9'h002 << code;
    return 8'(ratio - 9'h001);
  endfunction

endpackage

// File: verilog/preset_timer.sv
`timescale 1ns/1ps
module preset_timer
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Source clock tick and control
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic [2:0] code_i,
  input wire logic [7:0] preset_i,
  // Underflow event
  output logic uflow_o
);

  logic [7:0] pre_reg;
  logic [7:0] pre_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic uflow_next;
  wire step = run_i && tick_i && (pre_reg == ir_timer_pkg::ratio_last(code_i));
  wire at_zero = (cnt_reg == ir_timer_pkg::COUNT_ZERO);

  // A stopped timer stays loaded, so each phase starts from a full preset.
  always_comb
  begin
    pre_next = pre_reg;
    cnt_next = cnt_reg;
    uflow_next = 1'b0;
    if (!run_i)
    begin
      pre_next = ir_timer_pkg::COUNT_ZERO;
      cnt_next = preset_i;
    end
    else if (tick_i)
    begin
      pre_next = step ? ir_timer_pkg::COUNT_ZERO : 8'(pre_reg + 8'h01);
      if (step)
      begin
        cnt_next = at_zero ? preset_i : 8'(cnt_reg - 8'h01);
        uflow_next = at_zero;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pre_reg <= ir_timer_pkg::COUNT_RESET;
      cnt_reg <= ir_timer_pkg::COUNT_RESET;
      uflow_o <= 1'b0;
    end
    else
    begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      uflow_o <= uflow_next;
    end
  end

  reload_value_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_04
    uflow_o |-> cnt_reg == $past(preset_i))
    else $error("Timer did not reload its preset on underflow.");

endmodule

// File: verilog/ir_pwm_timer_set.sv
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] First timer: 8-bit down counter, 8-bit prescaler, preset reloads on underflow.
// [RULE_02] Second timer: same structure, its own readable and writable preset.
// [RULE_03] Second timer toggles the carrier; frequency is source/(2*(preset+1)*ratio).
// [RULE_04] High-pulse timer: 8-bit down counter, prescaler, preset reload on underflow.
// [RULE_05] High phase lasts ratio times (preset+1) high-timer source clocks.
// [RULE_06] Low-pulse timer: 8-bit down counter, prescaler, preset reload on underflow.
// [RULE_07] Low phase lasts ratio times (preset+1) low-timer source clocks.
// [RULE_08] Mask register holds one enable per source; fully readable and writable.
// [RULE_09] Bit 7 picks rising (0) or falling (1) edge for external interrupt 0.
// [RULE_10] Bit 6 reads global enable: cleared by disable or entry, set by enable/return.
// [RULE_11] Bit 5 picks instruction clock (0) or external pin transitions (1).
// [RULE_12] External count source period must exceed the instruction clock period.
// [RULE_13] Bit 4 counts rising (0) or falling (1) pin edges.
// [RULE_14] Prescaler off gives 1:1; on, codes 0 to 7 give 1:2 to 1:256.
// [RULE_15] Each timer selects sub (0) or main (1) oscillator and a 1:2-1:256 ratio.
// [RULE_16] IR mode with modulator on: low sections carry the second timer carrier.
// [RULE_17] Long-low option ignores the high preset; low timer alone shapes the output.
// [RULE_18] Each timer underflow sets its own sticky status flag.
// [RULE_19] PWM alternates high and low phases, each starting on the other's underflow.
module ir_pwm_timer_set
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // IO-control register access
  input wire logic IOC_PAGE_I,
  input wire logic [3:0] IOC_ADDR_I,
  input wire logic IOC_WR_I,
  input wire logic [7:0] IOC_WDATA_I,
  output logic [7:0] IOC_RDATA_O,
  // Output waveform control
  input wire logic IR_EN_I,
  input wire logic CARRIER_MOD_EN_I,
  input wire logic LONG_LOW_OPT_I,
  input wire logic [1:0] COUNTER_RUN_I,
  // Processor events
  input wire logic INSTR_CYC_I,
  input wire logic IRQ_OFF_INSTR_I,
  input wire logic IRQ_ON_INSTR_I,
  input wire logic RETURN_FROM_IRQ_INSTR_I,
  input wire logic IRQ_ENTRY_I,
  input wire logic [7:0] FLAG_CLR_I,
  // Pins and oscillators
  input wire logic SUB_OSC_CLK_I,
  input wire logic MAIN_OSC_CLK_I,
  input wire logic MAIN_TIMER_PIN_I,
  input wire logic EXT_INT0_PIN_I,
  // Results
  output logic IR_PWM_OUT_PIN_O,
  output logic IRQ_REQ_O,
  output logic [7:0] FLAGS_O,
  output logic [7:0] MAIN_TIMER8_O
);

  function automatic logic hit(input logic page, input logic [3:0] addr,
                               input logic want_page, input logic [3:0] want_addr);
    return (page == want_page) && (addr == want_addr);
  endfunction

  logic [7:0] main_ctl_reg;
  logic [7:0] timer12_ctl_reg;
  logic [7:0] pulse_ctl_reg;
  logic [7:0] preset_reg [4];
  logic [7:0] irq_mask_reg;
  logic gie_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] main_pre_reg;
  logic [7:0] main_pre_next;
  logic [7:0] main_cnt_reg;
  logic [7:0] main_cnt_next;
  logic main_ovf;
  logic phase_high_reg;
  logic phase_high_next;
  logic carrier_reg;
  logic carrier_next;
  logic [7:0] rdata_next;

  // Two flip-flops before any logic reads a pin or an oscillator.
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  wire [3:0] pins_in = {EXT_INT0_PIN_I, MAIN_TIMER_PIN_I, MAIN_OSC_CLK_I, SUB_OSC_CLK_I};
  wire [3:0] rise = sync2_reg & ~sync3_reg;
  wire [3:0] fall = ~sync2_reg & sync3_reg;

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
    end
    else
    begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Register write decode.
  wire wr_main = IOC_WR_I && hit(IOC_PAGE_I, IOC_ADDR_I, ir_timer_pkg::PAGE_CONTROLS,
                                 ir_timer_pkg::MAIN_TIMER_CONTROL_OFS);
  wire wr_t12 = IOC_WR_I && hit(IOC_PAGE_I, IOC_ADDR_I, ir_timer_pkg::PAGE_CONTROLS,
                                ir_timer_pkg::TIMER12_CONTROL_OFS);
  wire wr_pulse = IOC_WR_I && hit(IOC_PAGE_I, IOC_ADDR_I, ir_timer_pkg::PAGE_CONTROLS,
                                  ir_timer_pkg::PULSE_CONTROL_OFS);
  wire wr_mask = IOC_WR_I && hit(IOC_PAGE_I, IOC_ADDR_I, ir_timer_pkg::PAGE_PRESETS,
                                 ir_timer_pkg::IRQ_MASK_OFS);
  wire [3:0] wr_preset;

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      main_ctl_reg <= ir_timer_pkg::REG_RESET;
      timer12_ctl_reg <= ir_timer_pkg::REG_RESET;
      pulse_ctl_reg <= ir_timer_pkg::REG_RESET;
      irq_mask_reg <= ir_timer_pkg::REG_RESET;
    end
    else
    begin
      // The global enable bit is read only, so a write never touches it.
      if (wr_main)
        main_ctl_reg <= IOC_WDATA_I & ~(8'h01 << ir_timer_pkg::GIE_BIT);
      if (wr_t12)
        timer12_ctl_reg <= IOC_WDATA_I;
      if (wr_pulse)
        pulse_ctl_reg <= IOC_WDATA_I;
      // [RULE_08] Mask write.
      if (wr_mask)
        irq_mask_reg <= IOC_WDATA_I;
    end
  end

  // Per-timer source, ratio, run and preset, one slice per timer.
  logic [3:0] src_sel;
  logic [2:0] code [4];
  logic [3:0] run;
  logic [3:0] tick;
  logic [3:0] uflow;

  assign src_sel = {pulse_ctl_reg[ir_timer_pkg::UPPER_SRC_BIT],
                    pulse_ctl_reg[ir_timer_pkg::LOWER_SRC_BIT],
                    timer12_ctl_reg[ir_timer_pkg::UPPER_SRC_BIT],
                    timer12_ctl_reg[ir_timer_pkg::LOWER_SRC_BIT]};
  assign code[ir_timer_pkg::FIRST_IDX] = timer12_ctl_reg[2:0];
  assign code[ir_timer_pkg::SECOND_IDX] = timer12_ctl_reg[6:4];
  assign code[ir_timer_pkg::HIGH_IDX] = pulse_ctl_reg[2:0];
  assign code[ir_timer_pkg::LOW_IDX] = pulse_ctl_reg[6:4];

  // [RULE_17] Long-low option holds the high timer.
  assign run[ir_timer_pkg::FIRST_IDX] = COUNTER_RUN_I[0];
  assign run[ir_timer_pkg::SECOND_IDX] = COUNTER_RUN_I[1] || (IR_EN_I && CARRIER_MOD_EN_I);
  assign run[ir_timer_pkg::HIGH_IDX] = IR_EN_I && phase_high_reg && !LONG_LOW_OPT_I;
  assign run[ir_timer_pkg::LOW_IDX] = IR_EN_I && (!phase_high_reg || LONG_LOW_OPT_I);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_timer
      assign wr_preset[gi] = IOC_WR_I && hit(IOC_PAGE_I, IOC_ADDR_I,
        ir_timer_pkg::PAGE_PRESETS, 4'(ir_timer_pkg::FIRST_TIMER_PRESET_OFS + 4'(gi)));
      // [RULE_15] Sub oscillator when 0, main oscillator when 1.
      assign tick[gi] = src_sel[gi] ? rise[1] : rise[0];

      always_ff @(posedge MCLK_I)
      begin
        if (!RST_N_I)
          preset_reg[gi] <= ir_timer_pkg::REG_RESET;
        else if (wr_preset[gi])
          preset_reg[gi] <= IOC_WDATA_I;
      end

      // [RULE_01] [RULE_02] [RULE_04] [RULE_06] Down counter with reload.
      preset_timer u_timer
      (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .tick_i(tick[gi]),
        .run_i(run[gi]),
        .code_i(code[gi]),
        .preset_i(preset_reg[gi]),
        .uflow_o(uflow[gi])
      );
    end
  endgenerate

  // Main timer event source and prescaler.
  wire src_ext = main_ctl_reg[ir_timer_pkg::SRC_SEL_BIT];
  wire pre_on = main_ctl_reg[ir_timer_pkg::PRESCALER_ON_BIT];
  // [RULE_13] Pin edge choice.
  wire pin_evt = main_ctl_reg[ir_timer_pkg::PIN_EDGE_BIT] ? fall[2] : rise[2];
  // [RULE_11] Instruction clock or pin transitions; the pin must run slower.
  wire main_evt = src_ext ? pin_evt : INSTR_CYC_I;
  // [RULE_14] Ratio 1:1 or 1:2 up to 1:256.
  wire pre_done = !pre_on || (main_pre_reg == ir_timer_pkg::ratio_last(main_ctl_reg[2:0]));
  wire main_step = main_evt && pre_done;

  always_comb
  begin
    main_pre_next = main_pre_reg;
    main_cnt_next = main_cnt_reg;
    if (main_evt)
      main_pre_next = pre_done ? ir_timer_pkg::COUNT_ZERO : 8'(main_pre_reg + 8'h01);
    if (main_step)
      main_cnt_next = 8'(main_cnt_reg + 8'h01);
  end

  assign main_ovf = main_step && (main_cnt_reg == ir_timer_pkg::COUNT_LAST);

  // [RULE_09] External interrupt 0 edge choice.
  wire int0_evt = main_ctl_reg[ir_timer_pkg::INT0_EDGE_BIT] ? fall[3] : rise[3];

  // [RULE_18] Sticky flags; a set in the cycle of its clear wins.
  always_comb
  begin
    flags_next = flags_reg & ~FLAG_CLR_I;
    flags_next[ir_timer_pkg::MAIN_TIMER_FLAG] =
      flags_next[ir_timer_pkg::MAIN_TIMER_FLAG] || main_ovf;
    flags_next[ir_timer_pkg::INT0_FLAG] = flags_next[ir_timer_pkg::INT0_FLAG] || int0_evt;
    flags_next[ir_timer_pkg::TIMER_FLAG_BASE +: 4] =
      flags_next[ir_timer_pkg::TIMER_FLAG_BASE +: 4] | uflow;
    flags_next[2] = 1'b0;
    flags_next[7] = 1'b0;
  end

  // [RULE_05] [RULE_07] Each phase lasts one full timer period.
  // [RULE_19] Phase sequence of the output waveform.
  always_comb
  begin
    phase_high_next = phase_high_reg;
    if (!IR_EN_I)
      phase_high_next = 1'b1;
    else if (LONG_LOW_OPT_I)
      phase_high_next = uflow[ir_timer_pkg::LOW_IDX] ? !phase_high_reg : phase_high_reg;
    else if (uflow[ir_timer_pkg::HIGH_IDX])
      phase_high_next = 1'b0;
    else if (uflow[ir_timer_pkg::LOW_IDX])
      phase_high_next = 1'b1;
  end

  // [RULE_03] Carrier toggles on each second-timer underflow while IR mode and the modulator are on; otherwise it is held at 0.
  assign carrier_next = (IR_EN_I && CARRIER_MOD_EN_I) ?
    (carrier_reg ^ uflow[ir_timer_pkg::SECOND_IDX]) : 1'b0;

  // [RULE_16] Low sections carry the carrier in IR mode with the modulator on.
  wire out_next = IR_EN_I && (phase_high_reg || (CARRIER_MOD_EN_I && carrier_reg));

  // Register read mux; unmapped addresses read zero.
  wire [7:0] main_rd = main_ctl_reg | (8'(gie_reg) << ir_timer_pkg::GIE_BIT);
  always_comb
  begin
    rdata_next = 8'h00;
    if (hit(IOC_PAGE_I, IOC_ADDR_I, ir_timer_pkg::PAGE_CONTROLS,
            ir_timer_pkg::MAIN_TIMER_CONTROL_OFS))
      rdata_next = main_rd;
    else if (hit(IOC_PAGE_I, IOC_ADDR_I, ir_timer_pkg::PAGE_CONTROLS,
                 ir_timer_pkg::TIMER12_CONTROL_OFS))
      rdata_next = timer12_ctl_reg;
    else if (hit(IOC_PAGE_I, IOC_ADDR_I, ir_timer_pkg::PAGE_CONTROLS,
                 ir_timer_pkg::PULSE_CONTROL_OFS))
      rdata_next = pulse_ctl_reg;
    else if (hit(IOC_PAGE_I, IOC_ADDR_I, ir_timer_pkg::PAGE_PRESETS,
                 ir_timer_pkg::IRQ_MASK_OFS))
      rdata_next = irq_mask_reg;
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (hit(IOC_PAGE_I, IOC_ADDR_I, ir_timer_pkg::PAGE_PRESETS,
                4'(ir_timer_pkg::FIRST_TIMER_PRESET_OFS + 4'(i))))
          rdata_next = preset_reg[i];
      end
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      main_pre_reg <= ir_timer_pkg::COUNT_RESET;
      main_cnt_reg <= ir_timer_pkg::COUNT_RESET;
      flags_reg <= ir_timer_pkg::REG_RESET;
      phase_high_reg <= 1'b1;
      carrier_reg <= 1'b0;
      gie_reg <= 1'b0;
    end
    else
    begin
      main_pre_reg <= main_pre_next;
      main_cnt_reg <= main_cnt_next;
      flags_reg <= flags_next;
      phase_high_reg <= phase_high_next;
      carrier_reg <= carrier_next;
      // [RULE_10] Disable and entry win over enable in the same cycle.
      if (IRQ_OFF_INSTR_I || IRQ_ENTRY_I)
        gie_reg <= 1'b0;
      else if (IRQ_ON_INSTR_I || RETURN_FROM_IRQ_INSTR_I)
        gie_reg <= 1'b1;
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      IOC_RDATA_O <= 8'h00;
      IR_PWM_OUT_PIN_O <= 1'b0;
      IRQ_REQ_O <= 1'b0;
      FLAGS_O <= 8'h00;
      MAIN_TIMER8_O <= 8'h00;
    end
    else
    begin
      IOC_RDATA_O <= rdata_next;
      IR_PWM_OUT_PIN_O <= out_next;
      IRQ_REQ_O <= gie_reg && |(flags_reg & irq_mask_reg);
      FLAGS_O <= flags_next;
      MAIN_TIMER8_O <= main_cnt_next;
    end
  end

  first_flag_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // RULE_18
    uflow[0] |=> flags_reg[ir_timer_pkg::TIMER_FLAG_BASE])
    else $error("First timer underflow did not set its flag.");
  second_flag_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // RULE_18
    uflow[1] |=> FLAGS_O[ir_timer_pkg::TIMER_FLAG_BASE + 1])
    else $error("Second timer underflow did not set its flag.");
  carrier_toggle_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // RULE_03
    (IR_EN_I && CARRIER_MOD_EN_I && uflow[1]) ##1 (IR_EN_I && CARRIER_MOD_EN_I)
      |-> carrier_reg != $past(carrier_reg))
    else $error("Carrier did not toggle on second timer underflow.");
  high_end_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // RULE_05
    (IR_EN_I && !LONG_LOW_OPT_I && uflow[2]) ##1 IR_EN_I |-> !phase_high_reg)
    else $error("High phase did not end on high timer underflow.");
  low_end_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // RULE_07
    (IR_EN_I && !LONG_LOW_OPT_I && uflow[3]) ##1 IR_EN_I |-> phase_high_reg)
    else $error("Low phase did not end on low timer underflow.");
  mask_write_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // RULE_08
    wr_mask |=> irq_mask_reg == $past(IOC_WDATA_I))
    else $error("Mask register did not take the written value.");
  gie_clear_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // RULE_10
    (IRQ_OFF_INSTR_I || IRQ_ENTRY_I) |=> !gie_reg ##1 !IRQ_REQ_O)
    else $error("Global enable not cleared by disable or entry.");
  gie_set_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // RULE_10
    (RETURN_FROM_IRQ_INSTR_I && !IRQ_OFF_INSTR_I && !IRQ_ENTRY_I) |=> gie_reg)
    else $error("Global enable not set by return.");
  int0_edge_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // RULE_09
    (!main_ctl_reg[ir_timer_pkg::INT0_EDGE_BIT] && rise[3]) |=> FLAGS_O[1])
    else $error("Rising edge on interrupt pin did not set its flag.");
  tcc_step_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // RULE_11
    (!src_ext && !pre_on && INSTR_CYC_I) |=> main_cnt_reg == 8'($past(main_cnt_reg) + 8'h01))
    else $error("Main timer did not step on instruction clock.");
  long_low_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // RULE_17
    LONG_LOW_OPT_I |=> !uflow[2])
    else $error("High timer ran while long-low option is set.");
  low_mod_a: assert property (@(posedge MCLK_I) disable iff (!RST_N_I) // RULE_16
    (IR_EN_I && !phase_high_reg && !CARRIER_MOD_EN_I) |=> !IR_PWM_OUT_PIN_O)
    else $error("Unmodulated low section was not low.");

endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_n, pg, wr_en, ir_en, mod_en, long_low, sub_osc, main_osc, tpin, ipin;
  logic [3:0] addr;
  logic [7:0] wdata, fclr, rdata, flags, tcount;
  logic [1:0] run;
  logic [4:0] ev_v;
  logic out_pin, irq, rd_flag;
  logic [7:0] exp_q[$];
  logic [31:0] seed, r;
  logic [4:0] map[8] = '{5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h17, 5'h19, 5'h1A};
  int n_errors, checks, osc_cnt, n;

  ir_pwm_timer_set dut
  (
    .MCLK_I(clk),
    .RST_N_I(rst_n),
    .IOC_PAGE_I(pg),
    .IOC_ADDR_I(addr),
    .IOC_WR_I(wr_en),
    .IOC_WDATA_I(wdata),
    .IOC_RDATA_O(rdata),
    .IR_EN_I(ir_en),
    .CARRIER_MOD_EN_I(mod_en),
    .LONG_LOW_OPT_I(long_low),
    .COUNTER_RUN_I(run),
    .INSTR_CYC_I(ev_v[4]),
    .IRQ_OFF_INSTR_I(ev_v[0]),
    .IRQ_ON_INSTR_I(ev_v[1]),
    .RETURN_FROM_IRQ_INSTR_I(ev_v[2]),
    .IRQ_ENTRY_I(ev_v[3]),
    .FLAG_CLR_I(fclr),
    .SUB_OSC_CLK_I(sub_osc),
    .MAIN_OSC_CLK_I(main_osc),
    .MAIN_TIMER_PIN_I(tpin),
    .EXT_INT0_PIN_I(ipin),
    .IR_PWM_OUT_PIN_O(out_pin),
    .IRQ_REQ_O(irq),
    .FLAGS_O(flags),
    .MAIN_TIMER8_O(tcount)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Main oscillator ticks every 4 cycles, sub every 6, so periods are exact.
  always @(negedge clk)
  begin
    osc_cnt <= osc_cnt + 1;
    if (osc_cnt % 2 == 1)
      main_osc <= ~main_osc;
    if (osc_cnt % 3 == 2)
      sub_osc <= ~sub_osc;
  end

  // Read data lands one edge after the address, so look just after that edge.
  always @(posedge clk)
  begin
    if (rd_flag === 1'b1)
    begin
      #1;
      cmp8(rdata, exp_q.pop_front());
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic err(input string s);
    n_errors++;
    $display("[ERR] %0t %s", $time, s);
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    if (got !== exp)
      n_errors++;
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
      err("bit mismatch");
  endtask

  task automatic cmp_cnt(input int got, input int exp);
    checks++;
    if (got != exp)
      $display("[ERR] %0t cycles %0d expected %0d", $time, got, exp);
    if (got != exp)
      n_errors++;
  endtask

  task automatic wt(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic wr_reg(input logic [4:0] pa, input logic [7:0] d);
    @(negedge clk);
    {pg, addr} = pa;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask

  task automatic rd_reg(input logic [4:0] pa, input logic [7:0] exp);
    @(negedge clk);
    {pg, addr} = pa;
    exp_q.push_back(exp);
    rd_flag = 1'b1;
    @(negedge clk);
    rd_flag = 1'b0;
  endtask

  task automatic ev(input logic [4:0] m);
    @(negedge clk);
    ev_v = m;
    @(negedge clk);
    ev_v = 5'h00;
  endtask

  task automatic clr(input logic [7:0] m);
    @(negedge clk);
    fclr = m;
    @(negedge clk);
    fclr = 8'h00;
  endtask

  // Each pin level stands six cycles, slower than the instruction pulses.
  task automatic pins(input logic t, input logic i);
    @(negedge clk);
    tpin = t;
    ipin = i;
    wt(6);
  endtask

  task automatic wflag(input int b, output int k);
    k = 0;
    while (flags[b] !== 1'b1 && k < 20000)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 20000)
      err("flag wait ran out");
  endtask

  // Measures one underflow period; the clear pulse costs two of its cycles.
  task automatic per(input int b, output int k);
    logic [7:0] m;
    m = 8'h00;
    m[b] = 1'b1;
    clr(m);
    wflag(b, k);
    clr(m);
    wflag(b, k);
    k = k + 2;
  endtask

  task automatic pw(input logic lvl, output int k);
    int g;
    g = 0;
    k = 0;
    while (out_pin !== !lvl && g < 20000)
    begin
      @(negedge clk);
      g++;
    end
    while (out_pin !== lvl && g < 20000)
    begin
      @(negedge clk);
      g++;
    end
    while (out_pin === lvl && k < 20000)
    begin
      @(negedge clk);
      k++;
    end
    if (g >= 20000 || k >= 20000)
      err("waveform wait ran out");
  endtask

  task automatic summarize();
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    err("watchdog expired");
    summarize();
  end

  initial
  begin
    {rst_n, pg, wr_en, ir_en, mod_en, long_low, sub_osc, main_osc, tpin, ipin} = 10'h000;
    {addr, wdata, fclr, run, ev_v, rd_flag} = 28'h000_0000;
    {n_errors, checks, osc_cnt} = {32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    seed = 32'h055f_d16d;
    wt(8);
    rst_n = 1'b1;
    wt(1);
    cmp8(flags, 8'h00);
    cmp_bit(out_pin, 1'b0);
    foreach (map[i])
      rd_reg(map[i], 8'h00);
    foreach (map[i])
    begin
      r = xs();
      wr_reg(map[i], r[7:0]);
      rd_reg(map[i], (map[i] == 5'h17) ? (r[7:0] & 8'hBF) : r[7:0]);
    end
    wr_reg(5'h08, 8'h5A);
    rd_reg(5'h08, 8'h00);
    rd_reg(5'h1B, 8'h00);
    wr_reg(5'h17, 8'h00);
    ev(5'b00010);
    rd_reg(5'h17, 8'h40);
    ev(5'b00011);
    rd_reg(5'h17, 8'h00);
    ev(5'b00100);
    rd_reg(5'h17, 8'h40);
    ev(5'b01000);
    rd_reg(5'h17, 8'h00);
    ev(5'b00010);
    repeat (5) ev(5'b10000);
    wt(3);
    cmp8(tcount, 8'h05);
    wr_reg(5'h17, 8'h09);
    repeat (8) ev(5'b10000);
    wt(3);
    cmp8(tcount, 8'h07);
    wr_reg(5'h17, 8'h20);
    pins(1'b1, 1'b0);
    cmp8(tcount, 8'h08);
    pins(1'b0, 1'b0);
    cmp8(tcount, 8'h08);
    wr_reg(5'h17, 8'h30);
    pins(1'b1, 1'b0);
    cmp8(tcount, 8'h08);
    pins(1'b0, 1'b0);
    cmp8(tcount, 8'h09);
    wr_reg(5'h17, 8'h00);
    repeat (247) ev(5'b10000);
    wt(3);
    cmp8(tcount, 8'h00);
    cmp_bit(flags[0], 1'b1);
    wr_reg(5'h0F, 8'h01);
    wt(3);
    cmp_bit(irq, 1'b1);
    wr_reg(5'h0F, 8'hFE);
    wt(3);
    cmp_bit(irq, 1'b0);
    wr_reg(5'h0F, 8'h01);
    ev(5'b00001);
    wt(2);
    cmp_bit(irq, 1'b0);
    ev(5'b00010);
    clr(8'h01);
    wt(2);
    cmp8(flags, 8'h00);
    pins(1'b0, 1'b1);
    cmp_bit(flags[1], 1'b1);
    clr(8'h02);
    pins(1'b0, 1'b0);
    cmp_bit(flags[1], 1'b0);
    wr_reg(5'h17, 8'h80);
    pins(1'b0, 1'b1);
    cmp_bit(flags[1], 1'b0);
    pins(1'b0, 1'b0);
    cmp_bit(flags[1], 1'b1);
    wr_reg(5'h0B, 8'h02);
    wr_reg(5'h0C, 8'h01);
    wr_reg(5'h19, 8'h18);
    run = 2'b11;
    per(3, n);
    cmp_cnt(n, 24);
    per(3, n);
    cmp_cnt(n, 24);
    per(4, n);
    cmp_cnt(n, 48);
    run = 2'b00;
    wr_reg(5'h0D, 8'h03);
    wr_reg(5'h0E, 8'h05);
    wr_reg(5'h1A, 8'h98);
    ir_en = 1'b1;
    pw(1'b1, n);
    pw(1'b1, n);
    cmp_cnt(n, 32);
    pw(1'b0, n);
    cmp_cnt(n, 96);
    cmp_bit(flags[5] & flags[6], 1'b1);
    long_low = 1'b1;
    pw(1'b1, n);
    pw(1'b1, n);
    cmp_cnt(n, 96);
    long_low = 1'b0;
    wr_reg(5'h0D, 8'h00);
    wr_reg(5'h0E, 8'hFF);
    wr_reg(5'h1A, 8'hA8);
    wr_reg(5'h19, 8'h88);
    mod_en = 1'b1;
    clr(8'h20);
    wflag(5, n);
    wt(40);
    pw(1'b1, n);
    cmp_cnt(n, 16);
    pw(1'b0, n);
    cmp_cnt(n, 16);
    ir_en = 1'b0;
    wt(3);
    cmp_bit(out_pin, 1'b0);
    summarize();
  end
endmodule
